// >>> inc/synth_ctrl_pkg.sv
// shared constants and types for the synthesiser serial control block
package synth_ctrl_pkg;
	// fixed upper part of the slave address, msb first
	localparam logic [4:0] ADDR_FIXED    = 5'h18;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] CNT_ZERO      = 4'h0;
	localparam logic [3:0] CNT_ONE       = 4'h1;

	// values after reset or after loss of supply
	localparam logic [16:0] DIVIDER_RST  = 17'h00000;
	localparam logic        PRESCALE_RST = 1'b0;
	localparam logic [3:0]  REFDIV_RST   = 4'h0;
	localparam logic [1:0]  PUMP_RST     = 2'h0;
	localparam logic        GATE_RST     = 1'b1;
	localparam logic        OUTSEL_RST   = 1'b1;
	localparam logic [3:0]  PORTS_RST    = 4'h0;
	localparam logic [2:0]  TEST_RST     = 3'h0;
	localparam logic        FLAG_RST     = 1'b1;

	// field positions in the write bytes
	localparam int B_KIND      = 7;
	localparam int B2_DIV_LSB  = 0;
	localparam int B4_DIV_LSB  = 5;
	localparam int B4_PRESCALE = 4;
	localparam int B4_REFDIV   = 0;
	localparam int B5_PUMP     = 6;
	localparam int B5_GATE     = 5;
	localparam int B5_SEL      = 4;
	localparam int B5_PORT3    = 3;
	localparam int B5_SHARED   = 0;

	// field positions in the status byte
	localparam int ST_FLAG = 7;
	localparam int ST_LOCK = 6;

	// test function codes in the low two select bits, varactor disable in select bit 2
	localparam logic [1:0] TEST_SINK    = 2'h0;
	localparam logic [1:0] TEST_SOURCE  = 2'h1;
	localparam logic [1:0] TEST_PUMPOFF = 2'h2;
	localparam logic [1:0] TEST_DIVOUT  = 2'h3;
	localparam int         TEST_VARACTOR = 2;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_ADDR  = 3'b001,
		S_AACK  = 3'b010,
		S_WDATA = 3'b011,
		S_WACK  = 3'b100,
		S_RDATA = 3'b101,
		S_RACK  = 3'b110
	} i2c_state_t;
endpackage : synth_ctrl_pkg

// >>> rtl/i2c_line_sync.sv
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sync #(
	parameter int               LINES = 3,
	parameter logic [LINES-1:0] IDLE  = '1
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [LINES-1:0] rawIn,
	output logic      [LINES-1:0] level,
	output logic      [LINES-1:0] rise,
	output logic      [LINES-1:0] fall
);
	logic [LINES-1:0] stage1_q;
	logic [LINES-1:0] stage2_q;
	logic [LINES-1:0] stage3_q;

	genvar i;
	generate
		for (i = 0; i < LINES; i++) begin : g_line
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					stage1_q[i] <= IDLE[i];
					stage2_q[i] <= IDLE[i];
					stage3_q[i] <= IDLE[i];
				end else begin
					stage1_q[i] <= rawIn[i];
					stage2_q[i] <= stage1_q[i];
					stage3_q[i] <= stage2_q[i];
				end
			end

			// a change counts once the last two stages agree
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					level[i] <= IDLE[i];
					rise[i]  <= 1'b0;
					fall[i]  <= 1'b0;
				end else if (stage2_q[i] == stage3_q[i] &&
				             stage3_q[i] != level[i]) begin
					level[i] <= stage3_q[i];
					rise[i]  <= stage3_q[i];
					fall[i]  <= ~stage3_q[i];
				end else begin
					rise[i] <= 1'b0;
					fall[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : i2c_line_sync
`default_nettype wire

// >>> rtl/synth_i2c_control_regs.sv
// serial control registers and status readback for the synthesiser
`timescale 1ns/1ps
`default_nettype none
// Function
// - prescaler enable bit selects divide-by-two path
// - prescaler enable is a static level
// - two-bit code selects one of four currents
// - test mode when gate low, select high
// - test writes keep stored low port bits
// - gate high, select low routes reference
// - gate high, select high routes comparison
// - gate low forces output high
// - gate and select default to one
// - address is 11000, variant, read/write bit
// - variant bits come from address level
// - bytes msb first; divider word layout
// - control bytes carry listed fields
// - select bit meaning depends on gate
// - port 0 follows byte except test
// - status: flag, lock, three zeros, adc
// - adc code reported from five bands
// - test sink/source force pump and lock
// - top test bit disables varactor drive
// - first byte msb picks byte pair
// - divider applied on all bits or stop
// - master nack ends the read
// - flag cleared by stop after read
module synth_i2c_control_regs
	import synth_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeB,
	input  wire logic        supplyLowIn,
	input  wire logic [1:0]  addrVariant,
	input  wire logic        lockIn,
	input  wire logic [2:0]  adcCode,
	input  wire logic        refFreqIn,
	input  wire logic        compFreqIn,
	input  wire logic        dividerOutput,
	output logic      [16:0] dividerRatio,
	output logic             prescalerEnable,
	output logic      [3:0]  refdivSelect,
	output logic      [1:0]  pumpCurrentSel,
	output logic             pumpForceSink,
	output logic             pumpForceSource,
	output logic             pumpDisable,
	output logic             varactorDisable,
	output logic             refCompOut,
	output logic      [3:0]  portLevels,
	output logic      [3:0]  portOeB
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	i2c_state_t  state_q;
	logic [3:0]  bitCnt_q;
	logic [7:0]  rxByte_q;
	logic [7:0]  txByte_q;
	logic        sdaLow_q;
	logic        readMode_q;
	logic        readSeen_q;
	logic        pairSecond_q;
	logic        pairHigh_q;
	logic [16:0] divStage_q;
	logic        got2_q;
	logic        got3_q;
	logic        got4_q;
	logic [16:0] divider_q;
	logic        prescale_q;
	logic [3:0]  refdiv_q;
	logic [1:0]  pump_q;
	logic        gate_q;
	logic        outSel_q;
	logic [3:0]  ports_q;
	logic [2:0]  testSel_q;
	logic        flag_q;
	logic        divPrev_q;
	logic        divHalf_q;
	logic        refComp_q;
	logic [3:0]  portOut_q;
	logic [2:0]  lvl;
	logic [2:0]  rise;
	logic [2:0]  fall;
	logic        sclLvl;
	logic        sdaLvl;
	logic        supplyLow;
	logic        sclRise;
	logic        sclFall;
	logic        startEv;
	logic        stopEv;
	logic        addrMatch;
	logic        byteDone;
	logic        commit;
	logic        divLoad;
	logic        testMode;
	logic        lockRep;
	logic [7:0]  statusByte;

	// scl, sda and supply monitor share one filtered front end
	i2c_line_sync #(
		.LINES (3),
		.IDLE  (3'b011)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.rawIn ({supplyLowIn, sdaIn, sclIn}),
		.level (lvl),
		.rise  (rise),
		.fall  (fall)
	);

	assign sclLvl    = lvl[0];
	assign sdaLvl    = lvl[1];
	assign supplyLow = lvl[2];
	assign sclRise   = rise[0];
	assign sclFall   = fall[0];
	assign startEv   = fall[1] & sclLvl;
	assign stopEv    = rise[1] & sclLvl;

	assign addrMatch = rxByte_q[7:3] == ADDR_FIXED &&
	                   rxByte_q[2:1] == addrVariant;
	assign byteDone  = state_q == S_WDATA && sclFall &&
	                   bitCnt_q == BITS_PER_BYTE;

	// lock report is overridden by the sink and source tests
	assign testMode = ~gate_q & outSel_q;
	always_comb begin
		lockRep = lockIn;
		if (testMode && testSel_q[1:0] == TEST_SINK)
			lockRep = 1'b1;
		else if (testMode && testSel_q[1:0] == TEST_SOURCE)
			lockRep = 1'b0;
	end
	assign statusByte = {flag_q, lockRep, 3'h0, adcCode};

	// bus protocol: bits sampled on scl rise, sda changed on scl fall
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= S_IDLE;
			bitCnt_q   <= CNT_ZERO;
			rxByte_q   <= 8'h00;
			txByte_q   <= 8'h00;
			sdaLow_q   <= 1'b0;
			readMode_q <= 1'b0;
		end else if (stopEv) begin
			state_q  <= S_IDLE;
			sdaLow_q <= 1'b0;
		end else if (startEv) begin
			state_q  <= S_ADDR;
			bitCnt_q <= CNT_ZERO;
			sdaLow_q <= 1'b0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
				end
				S_ADDR, S_WDATA: begin
					if (sclRise) begin
						rxByte_q <= {rxByte_q[6:0], sdaLvl};
						bitCnt_q <= bitCnt_q + CNT_ONE;
					end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
						bitCnt_q <= CNT_ZERO;
						if (state_q == S_WDATA) begin
							sdaLow_q <= 1'b1;
							state_q  <= S_WACK;
						end else if (addrMatch) begin
							sdaLow_q   <= 1'b1;
							readMode_q <= rxByte_q[0];
							state_q    <= S_AACK;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_WACK: begin
					if (sclFall) begin
						sdaLow_q <= 1'b0;
						state_q  <= S_WDATA;
					end
				end
				S_AACK, S_RACK: begin
					if (sclRise && state_q == S_RACK && sdaLvl) begin
						state_q <= S_IDLE;
					end else if (sclFall) begin
						bitCnt_q <= CNT_ZERO;
						if (state_q == S_RACK || readMode_q) begin
							sdaLow_q <= ~statusByte[7];
							txByte_q <= {statusByte[6:0], 1'b0};
							state_q  <= S_RDATA;
						end else begin
							sdaLow_q <= 1'b0;
							state_q  <= S_WDATA;
						end
					end
				end
				S_RDATA: begin
					if (sclRise) begin
						bitCnt_q <= bitCnt_q + CNT_ONE;
					end else if (sclFall) begin
						if (bitCnt_q == BITS_PER_BYTE) begin
							sdaLow_q <= 1'b0;
							bitCnt_q <= CNT_ZERO;
							state_q  <= S_RACK;
						end else begin
							sdaLow_q <= ~txByte_q[7];
							txByte_q <= {txByte_q[6:0], 1'b0};
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOeB = ~sdaLow_q;

	// byte pairing and divider staging within one transfer
	assign commit  = (got2_q & got3_q & got4_q) |
	                 (stopEv & (got2_q | got3_q | got4_q));
	assign divLoad = commit | supplyLow;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pairSecond_q <= 1'b0;
			pairHigh_q   <= 1'b0;
			divStage_q   <= DIVIDER_RST;
			got2_q       <= 1'b0;
			got3_q       <= 1'b0;
			got4_q       <= 1'b0;
		end else if (supplyLow || startEv || commit) begin
			pairSecond_q <= pairSecond_q & ~startEv & ~supplyLow;
			if (supplyLow)
				divStage_q <= DIVIDER_RST;
			got2_q <= 1'b0;
			got3_q <= 1'b0;
			got4_q <= 1'b0;
		end else if (byteDone) begin
			pairSecond_q <= ~pairSecond_q;
			if (!pairSecond_q) begin
				pairHigh_q <= rxByte_q[B_KIND];
				if (rxByte_q[B_KIND]) begin
					divStage_q[16:15] <= rxByte_q[B4_DIV_LSB+:2];
					got4_q <= 1'b1;
				end else begin
					divStage_q[14:8] <= rxByte_q[B2_DIV_LSB+:7];
					got2_q <= 1'b1;
				end
			end else if (!pairHigh_q) begin
				divStage_q[7:0] <= rxByte_q;
				got3_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			divider_q <= DIVIDER_RST;
		else if (supplyLow)
			divider_q <= DIVIDER_RST;
		else if (commit)
			divider_q <= divStage_q;
	end

	// control bytes take effect as soon as each completes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_q <= PRESCALE_RST;
			refdiv_q   <= REFDIV_RST;
			pump_q     <= PUMP_RST;
			gate_q     <= GATE_RST;
			outSel_q   <= OUTSEL_RST;
			ports_q    <= PORTS_RST;
			testSel_q  <= TEST_RST;
		end else if (supplyLow) begin
			prescale_q <= PRESCALE_RST;
			refdiv_q   <= REFDIV_RST;
			pump_q     <= PUMP_RST;
			gate_q     <= GATE_RST;
			outSel_q   <= OUTSEL_RST;
			ports_q    <= PORTS_RST;
			testSel_q  <= TEST_RST;
		end else if (byteDone && !pairSecond_q && rxByte_q[B_KIND]) begin
			prescale_q <= rxByte_q[B4_PRESCALE];
			refdiv_q   <= rxByte_q[B4_REFDIV+:4];
		end else if (byteDone && pairSecond_q && pairHigh_q) begin
			pump_q     <= rxByte_q[B5_PUMP+:2];
			gate_q     <= rxByte_q[B5_GATE];
			outSel_q   <= rxByte_q[B5_SEL];
			ports_q[3] <= rxByte_q[B5_PORT3];
			if (!rxByte_q[B5_GATE] && rxByte_q[B5_SEL])
				testSel_q <= rxByte_q[B5_SHARED+:3];
			else
				ports_q[2:0] <= rxByte_q[B5_SHARED+:3];
		end
	end

	// power-on flag: a supply loss wins over the clearing stop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q     <= FLAG_RST;
			readSeen_q <= 1'b0;
		end else begin
			if (stopEv)
				readSeen_q <= 1'b0;
			else if (state_q == S_RDATA)
				readSeen_q <= 1'b1;
			if (supplyLow)
				flag_q <= 1'b1;
			else if (stopEv && readSeen_q)
				flag_q <= 1'b0;
		end
	end

	// output pins and divided test clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divPrev_q <= 1'b0;
			divHalf_q <= 1'b0;
			refComp_q <= 1'b1;
			portOut_q <= PORTS_RST;
		end else begin
			divPrev_q <= dividerOutput;
			if (dividerOutput && !divPrev_q)
				divHalf_q <= ~divHalf_q;
			if (!gate_q)
				refComp_q <= 1'b1;
			else if (outSel_q)
				refComp_q <= compFreqIn;
			else
				refComp_q <= refFreqIn;
			portOut_q[3:1] <= ports_q[3:1];
			if (testMode && testSel_q[1:0] == TEST_DIVOUT)
				portOut_q[0] <= divHalf_q;
			else
				portOut_q[0] <= ports_q[0];
		end
	end

	assign dividerRatio    = divider_q;
	assign prescalerEnable = prescale_q;
	assign refdivSelect    = refdiv_q;
	assign pumpCurrentSel  = pump_q;
	assign pumpForceSink   = testMode && testSel_q[1:0] == TEST_SINK;
	assign pumpForceSource = testMode && testSel_q[1:0] == TEST_SOURCE;
	assign pumpDisable     = testMode && testSel_q[1:0] == TEST_PUMPOFF;
	assign varactorDisable = testMode & testSel_q[TEST_VARACTOR];
	assign refCompOut      = refComp_q;
	assign portLevels      = portOut_q;
	assign portOeB         = {4{flag_q}};

	a_refcomp_high: assert property (!gate_q |=> refCompOut)
		else $error("ref/comp output not high while gated");
	a_ref_route: assert property (gate_q && !outSel_q |=>
		refCompOut == $past(refFreqIn))
		else $error("reference not routed to ref/comp output");
	a_comp_route: assert property (gate_q && outSel_q |=>
		refCompOut == $past(compFreqIn))
		else $error("comparison not routed to ref/comp output");
	a_test_sink: assert property (testMode && testSel_q[1:0] == TEST_SINK
		|-> pumpForceSink && !pumpForceSource && statusByte[ST_LOCK])
		else $error("sink test not forcing pump and lock report");
	a_port_keep: assert property (byteDone && pairSecond_q && pairHigh_q &&
		!rxByte_q[B5_GATE] && rxByte_q[B5_SEL] && !supplyLow
		|=> $stable(ports_q[2:0]))
		else $error("test write changed stored port bits");
	a_div_hold: assert property ($changed(divider_q) |-> $past(divLoad))
		else $error("divider changed without a commit");
	a_addr_ack: assert property (state_q == S_ADDR && sclFall && !stopEv &&
		!startEv && bitCnt_q == BITS_PER_BYTE && addrMatch
		|=> !sdaOeB && state_q == S_AACK)
		else $error("matching address not acknowledged");
	a_nack_stop: assert property (state_q == S_RACK && sclRise && sdaLvl &&
		!stopEv && !startEv |=> state_q == S_IDLE ##1 sdaOeB)
		else $error("read continued after master nack");
	a_flag_clear: assert property (stopEv && readSeen_q && !supplyLow
		|=> !flag_q)
		else $error("power-on flag not cleared by stop after read");
	a_port_hiz: assert property (supplyLow |=> portOeB == 4'hf)
		else $error("ports driven while power-on flag set");
	a_power_defaults: assert property (supplyLow |=> gate_q && outSel_q)
		else $error("gate and select not defaulted after supply loss");
	a_varactor_off: assert property (byteDone && pairSecond_q && pairHigh_q &&
		!rxByte_q[B5_GATE] && rxByte_q[B5_SEL] &&
		rxByte_q[B5_SHARED+TEST_VARACTOR] && !supplyLow
		|=> varactorDisable)
		else $error("varactor drive not disabled in test");

	c_write_commit: cover property (commit && got4_q);
	c_read_byte: cover property (state_q == S_RDATA ##[1:200] state_q == S_RACK);
	c_test_divout: cover property (testMode && testSel_q[1:0] == TEST_DIVOUT);
	c_master_nack: cover property (state_q == S_RACK && sclRise && sdaLvl);
endmodule : synth_i2c_control_regs
`default_nettype wire

// >>> test/i2c_bus_master.sv
// behavioural i2c bus controller driving the synthesiser serial pins
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
	input  wire logic clk,
	input  wire logic sdaLine,
	output var logic  sclLine,
	output var logic  sdaPull
);
	initial begin
		sclLine = 1'b1;
		sdaPull = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	// also serves as a repeated start from a low clock
	task automatic startCond();
		wt(6);
		sdaPull <= 1'b0;
		wt(6);
		sclLine <= 1'b1;
		wt(12);
		sdaPull <= 1'b1;
		wt(12);
		sclLine <= 1'b0;
	endtask : startCond

	task automatic stopCond();
		wt(6);
		sdaPull <= 1'b1;
		wt(6);
		sclLine <= 1'b1;
		wt(12);
		sdaPull <= 1'b0;
		wt(12);
	endtask : stopCond

	// data changes only while the clock is low, sampled mid-high
	task automatic bitIo(input logic b, output logic r);
		wt(6);
		sdaPull <= ~b;
		wt(6);
		sclLine <= 1'b1;
		wt(6);
		r = sdaLine;
		wt(6);
		sclLine <= 1'b0;
	endtask : bitIo

	// mAck high releases the ninth bit; ack returns the line level seen
	task automatic byteIo(input logic [7:0] wd, input logic mAck,
		output logic [7:0] rd, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitIo(wd[i], rd[i]);
		end
		bitIo(mAck, ack);
	endtask : byteIo
endmodule : i2c_bus_master
`default_nettype wire

// >>> test/tb_synth_i2c_control_regs.sv
// self-checking bench for the synthesiser serial control registers
`timescale 1ns/1ps
`default_nettype none
module tb_synth_i2c_control_regs;
	import synth_ctrl_pkg::*;
	logic        clk, rst_b, supplyLowIn, lockIn, refFreqIn, compFreqIn;
	logic        dividerOutput, sdaOut, sdaOeB, prescalerEnable, refCompOut;
	logic        pumpForceSink, pumpForceSource, pumpDisable, varactorDisable;
	logic [1:0]  addrVariant, pumpCurrentSel;
	logic [2:0]  adcCode;
	logic [3:0]  refdivSelect, portLevels, portOeB;
	logic [16:0] dividerRatio;
	logic [7:0]  st;
	logic        bitSeen;
	wire logic   sclLine, sdaPull, sdaLine;
	int          n_fail, total_checks, cycles;

	assign sdaLine = ~sdaPull & (sdaOeB ? 1'b1 : sdaOut);

	i2c_bus_master i_i2c_bus_master (.clk(clk), .sdaLine(sdaLine),
		.sclLine(sclLine), .sdaPull(sdaPull));

	synth_i2c_control_regs i_synth_i2c_control_regs (.clk(clk),
		.rst_b(rst_b), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOeB(sdaOeB), .supplyLowIn(supplyLowIn), .addrVariant(addrVariant),
		.lockIn(lockIn), .adcCode(adcCode), .refFreqIn(refFreqIn),
		.compFreqIn(compFreqIn), .dividerOutput(dividerOutput),
		.dividerRatio(dividerRatio), .prescalerEnable(prescalerEnable),
		.refdivSelect(refdivSelect), .pumpCurrentSel(pumpCurrentSel),
		.pumpForceSink(pumpForceSink), .pumpForceSource(pumpForceSource),
		.pumpDisable(pumpDisable), .varactorDisable(varactorDisable),
		.refCompOut(refCompOut), .portLevels(portLevels), .portOeB(portOeB));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	task automatic check(input string what, input logic [16:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results

	task automatic startAddr(input logic rw);
		logic       a;
		logic [7:0] rd;
		i_i2c_bus_master.startCond();
		i_i2c_bus_master.byteIo({ADDR_FIXED, addrVariant, rw}, 1'b1, rd, a);
		check("addrAck", 17'(a), 17'h0);
	endtask : startAddr

	task automatic sendB(input logic [7:0] b);
		logic       a;
		logic [7:0] rd;
		i_i2c_bus_master.byteIo(b, 1'b1, rd, a);
		check("dataAck", 17'(a), 17'h0);
	endtask : sendB

	// acknowledges every status byte but the last, then stops
	task automatic readStatus(input int n, output logic [7:0] s);
		logic a;
		startAddr(1'b1);
		for (int i = 0; i < n; i++) begin
			i_i2c_bus_master.byteIo(8'hff, 1'(i == n - 1), s, a);
		end
		i_i2c_bus_master.stopCond();
	endtask : readStatus

	task automatic writeCtl(input logic [7:0] b5);
		startAddr(1'b0);
		sendB(8'hd5);
		sendB(b5);
		i_i2c_bus_master.stopCond();
	endtask : writeCtl

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		rst_b = 1'b0;
		supplyLowIn = 1'b0;
		addrVariant = 2'h2;
		lockIn = 1'b1;
		adcCode = 3'h0;
		refFreqIn = 1'b1;
		compFreqIn = 1'b0;
		dividerOutput = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		check("refCompOut", 17'(refCompOut), 17'h0);
		check("portOeB", 17'(portOeB), 17'hf);
		// first read sees the power-on flag, its stop clears it
		for (int k = 0; k < 5; k++) begin
			addrVariant <= k[1:0];
			adcCode <= k[2:0];
			lockIn <= k[0];
			readStatus(2, st);
			check("status", 17'(st), 17'({k == 0, k[0], 3'h0, k[2:0]}));
		end
		check("portOeB", 17'(portOeB), 17'h0);
		i_i2c_bus_master.startCond();
		i_i2c_bus_master.byteIo({ADDR_FIXED, ~addrVariant, 1'b0}, 1'b1, st,
			bitSeen);
		check("wrongAddrAck", 17'(bitSeen), 17'h1);
		i_i2c_bus_master.stopCond();
		// divider stays staged until byte 4 completes the word
		startAddr(1'b0);
		sendB(8'h12);
		sendB(8'h34);
		check("dividerRatio", dividerRatio, 17'h0);
		sendB(8'hd5);
		i_i2c_bus_master.wt(12);
		check("dividerRatio", dividerRatio, 17'h11234);
		check("prescalerEnable", 17'(prescalerEnable), 17'h1);
		check("refdivSelect", 17'(refdivSelect), 17'h5);
		i_i2c_bus_master.stopCond();
		startAddr(1'b0);
		for (int i = 0; i < 4; i++) i_i2c_bus_master.bitIo(1'b0, bitSeen);
		i_i2c_bus_master.stopCond();
		check("dividerRatio", dividerRatio, 17'h11234);
		startAddr(1'b0);
		sendB(8'h7f);
		i_i2c_bus_master.stopCond();
		check("dividerRatio", dividerRatio, 17'h17f34);
		for (int c = 0; c < 4; c++) begin
			writeCtl({c[1:0], 2'b10, 4'(c + 9)});
			check("pumpCurrentSel", 17'(pumpCurrentSel), 17'(c));
			check("portLevels", 17'(portLevels), 17'(c + 9));
			check("refCompOut", 17'(refCompOut), 17'h1);
		end
		writeCtl(8'h33);
		check("refCompOut", 17'(refCompOut), 17'h0);
		for (int t = 0; t < 8; t++) begin
			writeCtl({2'h1, 3'b011, t[2:0]});
			check("ports", 17'(portLevels[3:1]), 17'h5);
			check("refCompOut", 17'(refCompOut), 17'h1);
			check("sink", 17'(pumpForceSink), 17'(t[1:0] == 2'h0));
			check("source", 17'(pumpForceSource), 17'(t[1:0] == 2'h1));
			check("pumpOff", 17'(pumpDisable), 17'(t[1:0] == 2'h2));
			check("varactor", 17'(varactorDisable), 17'(t[2]));
			check("pumpCurrentSel", 17'(pumpCurrentSel), 17'h1);
			// one divider edge must toggle the halved clock on port 0
			if (t[1:0] == 2'h3) begin
				bitSeen = portLevels[0];
				dividerOutput <= 1'b1;
				i_i2c_bus_master.wt(4);
				dividerOutput <= 1'b0;
				i_i2c_bus_master.wt(4);
				check("divHalf", 17'(portLevels[0]), 17'(!bitSeen));
			end
			// lock input set opposite to the forced report
			if (t[1] == 1'b0) begin
				lockIn <= t[0];
				readStatus(1, st);
				check("lock", 17'(st[6]), 17'(t[0] == 1'b0));
			end
		end
		writeCtl(8'h06);
		check("refCompOut", 17'(refCompOut), 17'h1);
		check("portLevels", 17'(portLevels), 17'h6);
		check("sink", 17'(pumpForceSink), 17'h0);
		check("varactor", 17'(varactorDisable), 17'h0);
		// supply loss wipes programming and floats the ports
		supplyLowIn <= 1'b1;
		i_i2c_bus_master.wt(10);
		supplyLowIn <= 1'b0;
		i_i2c_bus_master.wt(10);
		check("portOeB", 17'(portOeB), 17'hf);
		check("dividerRatio", dividerRatio, 17'h0);
		check("refCompOut", 17'(refCompOut), 17'h0);
		readStatus(1, st);
		check("flag", 17'(st[7]), 17'h1);
		results();
	end
endmodule : tb_synth_i2c_control_regs
`default_nettype wire
